// ===== logic/hpc_pkg.sv
// Package for the haptic playback control register bank
package hpc_pkg;
	// ==========================================================
	// Register offsets (printed offsets not multiples of four: index * 4)
	localparam logic [7:0] HPC_IDX_TOP_CTL = 8'h22;
	localparam logic [7:0] HPC_IDX_OVR_LVL = 8'h23;
	localparam logic [7:0] HPC_IDX_SEQ_CFG = 8'h24;
	localparam logic [7:0] HPC_IDX_STATUS = 8'h30;
	localparam logic [7:0] HPC_IDX_SEQ_CTRL = 8'h31;
	localparam logic [7:0] HPC_IDX_LEN = 8'h32;
	localparam logic [7:0] HPC_IDX_ACCEL = 8'h33;
	// ==========================================================
	// Field positions
	localparam int HPC_BIT_RUN = 4;
	localparam int HPC_BIT_STANDBY = 3;
	localparam int HPC_BIT_TIMEBASE = 2;
	localparam int HPC_BIT_WAVEGEN = 1;
	localparam int HPC_BIT_CHAIN = 0;
	localparam int HPC_BIT_SEQ_NEXT = 0;
	// ==========================================================
	// Reset values
	localparam logic [7:0] HPC_RST_TOP_CTL = 8'h00;
	localparam logic [7:0] HPC_RST_OVR_LVL = 8'h00;
	localparam logic [7:0] HPC_RST_SEQ_CFG = 8'h00;
	localparam logic [15:0] HPC_RST_LEN = 16'h0010;
	// ==========================================================
	// Override scaling constants
	localparam logic [7:0] HPC_OVR_FULL = 8'h7F;
	// ==========================================================
	// Frame timebase durations in microseconds, per selection
	localparam int HPC_FRAME_US_SLOW0 = 5440;
	localparam int HPC_FRAME_US_SLOW3 = 87040;
	localparam int HPC_FRAME_US_FAST0 = 1360;
	localparam int HPC_FRAME_US_FAST3 = 43520;
	// ==========================================================
	// Operating modes and power states
	typedef enum logic [2:0] {
		HPC_MODE_INACTIVE = 3'h0,
		HPC_MODE_DIRECT_LEVEL_OVERRIDE = 3'h1,
		HPC_MODE_PWM = 3'h2,
		HPC_MODE_REGISTER_TRIGGERED_MEMORY_PLAYBACK = 3'h3,
		HPC_MODE_EDGE_TRIGGERED_MEMORY_PLAYBACK = 3'h4
	} hpc_mode_t;
	typedef enum logic [1:0] {
		HPC_PWR_IDLE = 2'h0,
		HPC_PWR_STANDBY = 2'h1,
		HPC_PWR_ACTIVE = 2'h2
	} hpc_pwr_t;
	// ==========================================================
	// Drive command carried to the output stage
	typedef struct packed {
		logic active;
		logic [2:0] mode;
		logic signed [8:0] factor;
		logic use_abs_max;
		logic use_nom_max;
		logic timebase_sel;
		logic wave_gen_sel;
	} hpc_drive_t;
	// APB request
	typedef struct packed {
		logic sel;
		logic enable;
		logic write;
		logic [11:0] addr;
		logic [31:0] wdata;
	} hpc_apb_req_t;
endpackage : hpc_pkg

// ===== logic/hpc_ovr_scale.sv
// Override level to signed scaling factor conversion
`timescale 1ns/1ps
`default_nettype none
module hpc_ovr_scale (
	// Inputs
	input wire logic [7:0] level,
	input wire logic accel_en,
	// Result
	output logic signed [8:0] factor,
	output logic use_abs,
	output logic use_nom
);
	import hpc_pkg::*;
	always_comb begin
		// Negative codes clamp to zero when acceleration is on
		if (level[7] && accel_en) begin
			factor = 9'sh000; // [RQ7]
		end else begin
			factor = {level[7], level}; // [RQ5] [RQ7]
		end
		// Absolute max flag follows acceleration; nominal max flag is always set
		use_abs = accel_en; // [RQ6]
		use_nom = 1'b1; // [RQ6]
	end
endmodule : hpc_ovr_scale
`default_nettype wire

// ===== logic/hpc_seq_player.sv
// Memory sequence player with chained start
`timescale 1ns/1ps
`default_nettype none
module hpc_seq_player (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Control
	input wire logic run,
	input wire logic chain,
	input wire logic [15:0] seq_len,
	// Status
	output logic playing,
	output logic seq_done,
	output logic next_start
);
	import hpc_pkg::*;
	logic [15:0] cnt_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= 16'h0000;
			playing <= 1'b0;
			seq_done <= 1'b0;
			next_start <= 1'b0;
		end else begin
			seq_done <= 1'b0;
			next_start <= 1'b0;
			if (!run) begin
				playing <= 1'b0; // [RQ2]
				cnt_r <= 16'h0000;
			end else if (!playing) begin
				// Run is still set in the cycle after done; do not replay
				if (!seq_done) begin
					playing <= 1'b1; // [RQ1]
				end
				cnt_r <= 16'h0000;
			end else if (cnt_r + 16'h0001 >= seq_len) begin
				cnt_r <= 16'h0000;
				// Chain input lags its clear by a cycle; fire only once
				if (chain && !next_start) begin
					next_start <= 1'b1; // [RQ11]
				end else begin
					playing <= 1'b0;
					seq_done <= 1'b1;
				end
			end else begin
				cnt_r <= cnt_r + 16'h0001;
			end
		end
	end
endmodule : hpc_seq_player
`default_nettype wire

// ===== logic/hpc_top.sv
// Haptic playback control register bank with APB slave
//
// How it works
// RQ1 - Writing run bit one starts playback
// RQ2 - Writing run zero halts, returns idle
// RQ3 - Standby bit selects post-playback power state
// RQ4 - Mode field decodes five operating modes
// RQ5 - Override level scales drive, 0x7F full
// RQ6 - Scaling targets absolute or nominal maximum
// RQ7 - Negative codes signed, or zero with acceleration
// RQ8 - Timebase bit selects frame duration set
// RQ9 - Wave select bit picks custom sine drive
// RQ10 - Software sets back-EMF sensing per wave mode
// RQ11 - Chain bit starts next sequence at end
// RQ12 - Chain bit self-clears when next sequence starts
// RQ13 - Reserved mode codes behave as inactive
`timescale 1ns/1ps
`default_nettype none
module hpc_top (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Device context
	input wire logic accel_en,
	// Drive and power outputs
	output var hpc_pkg::hpc_drive_t drive,
	output var hpc_pkg::hpc_pwr_t pwr_state,
	output logic playing
);
	import hpc_pkg::*;

	// ==========================================================
	// Registers
	logic [7:0] top_ctl_r;
	logic [7:0] ovr_lvl_r;
	logic [7:0] seq_cfg_r;
	logic [15:0] seq_len_r;
	logic done_seen_r;
	logic [7:0] chain_count_r;
	logic [9:0] idx;
	logic wr_en;
	logic rd_en;
	logic mapped;
	logic wr_lane0;
	logic mode_mem;
	logic [2:0] mode_eff;
	logic seq_playing;
	logic seq_done;
	logic next_start;
	logic signed [8:0] factor;
	logic use_abs;
	logic use_nom;
	logic run_stop_wr;

	assign idx = paddr[11:2];
	assign wr_en = psel && penable && pwrite && pready;
	assign rd_en = psel && !penable && !pwrite;
	assign wr_lane0 = pstrb[0];
	assign mapped = (paddr[1:0] == 2'h0) &&
		((idx[7:0] == HPC_IDX_TOP_CTL) || (idx[7:0] == HPC_IDX_OVR_LVL) ||
		(idx[7:0] == HPC_IDX_SEQ_CFG) || (idx[7:0] == HPC_IDX_STATUS) ||
		(idx[7:0] == HPC_IDX_SEQ_CTRL) || (idx[7:0] == HPC_IDX_LEN) ||
		(idx[7:0] == HPC_IDX_ACCEL)) && (idx[9:8] == 2'h0);
	assign run_stop_wr = wr_en && wr_lane0 && mapped &&
		idx[7:0] == HPC_IDX_TOP_CTL && !pwdata[HPC_BIT_RUN];

	// ==========================================================
	// Mode decode, reserved codes act as inactive
	always_comb begin
		case (top_ctl_r[2:0])
			HPC_MODE_INACTIVE,
			HPC_MODE_DIRECT_LEVEL_OVERRIDE,
			HPC_MODE_PWM,
			HPC_MODE_REGISTER_TRIGGERED_MEMORY_PLAYBACK,
			HPC_MODE_EDGE_TRIGGERED_MEMORY_PLAYBACK: begin
				mode_eff = top_ctl_r[2:0]; // [RQ4]
			end
			default: begin
				mode_eff = HPC_MODE_INACTIVE; // [RQ13]
			end
		endcase
	end
	assign mode_mem = (mode_eff == HPC_MODE_REGISTER_TRIGGERED_MEMORY_PLAYBACK) ||
		(mode_eff == HPC_MODE_EDGE_TRIGGERED_MEMORY_PLAYBACK); // [RQ11]

	// ==========================================================
	// APB ready, no wait state so every access takes two cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= psel && !penable;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= psel && !penable && !mapped;
		end
	end

	// ==========================================================
	// Control register, run bit is cleared by hardware at end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			top_ctl_r <= HPC_RST_TOP_CTL;
		end else if (wr_en && wr_lane0 && mapped &&
			idx[7:0] == HPC_IDX_TOP_CTL) begin
			top_ctl_r <= {3'h0, pwdata[4:0]}; // [RQ1] [RQ2]
		end else if (seq_done) begin
			top_ctl_r[HPC_BIT_RUN] <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ovr_lvl_r <= HPC_RST_OVR_LVL;
		end else if (wr_en && wr_lane0 && mapped &&
			idx[7:0] == HPC_IDX_OVR_LVL) begin
			ovr_lvl_r <= pwdata[7:0];
		end
	end

	// Chain bit: hardware clear at next start; the clear wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seq_cfg_r <= HPC_RST_SEQ_CFG;
		end else begin
			if (wr_en && wr_lane0 && mapped &&
				idx[7:0] == HPC_IDX_SEQ_CFG) begin
				seq_cfg_r <= {5'h00, pwdata[2:0]};
			end
			if (next_start) begin
				seq_cfg_r[HPC_BIT_CHAIN] <= 1'b0; // [RQ12]
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seq_len_r <= HPC_RST_LEN;
		end else if (wr_en && wr_lane0 && mapped &&
			idx[7:0] == HPC_IDX_LEN) begin
			seq_len_r <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
		end
	end

	// Sticky completion flag; set wins over write-one clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_seen_r <= 1'b0;
		end else if (seq_done) begin
			done_seen_r <= 1'b1;
		end else if (wr_en && wr_lane0 && mapped &&
			idx[7:0] == HPC_IDX_STATUS && pwdata[0]) begin
			done_seen_r <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chain_count_r <= 8'h00;
		end else if (next_start) begin
			chain_count_r <= chain_count_r + 8'h01;
		end
	end

	// ==========================================================
	// Read data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_en && !mapped) begin
			prdata <= 32'h0000_0000;
		end else if (rd_en) begin
			case (idx[7:0])
				HPC_IDX_TOP_CTL: prdata <= {24'h0, top_ctl_r};
				HPC_IDX_OVR_LVL: prdata <= {24'h0, ovr_lvl_r};
				HPC_IDX_SEQ_CFG: prdata <= {24'h0, seq_cfg_r};
				HPC_IDX_STATUS: prdata <= {24'h0, chain_count_r[3:0],
					pwr_state, seq_playing, done_seen_r};
				HPC_IDX_LEN: prdata <= {16'h0, seq_len_r};
				HPC_IDX_ACCEL: prdata <= {31'h0, accel_en};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// ==========================================================
	// Sequence player and override scaling
	hpc_seq_player u_player (
		.pclk(pclk),
		.presetn(presetn),
		.run(top_ctl_r[HPC_BIT_RUN] && mode_mem),
		.chain(seq_cfg_r[HPC_BIT_CHAIN] && mode_mem),
		.seq_len(seq_len_r),
		.playing(seq_playing),
		.seq_done(seq_done),
		.next_start(next_start)
	);

	hpc_ovr_scale u_scale (
		.level(ovr_lvl_r),
		.accel_en(accel_en),
		.factor(factor),
		.use_abs(use_abs),
		.use_nom(use_nom)
	);

	// ==========================================================
	// Power state after playback
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwr_state <= HPC_PWR_IDLE;
		end else if (seq_playing ||
			mode_eff == HPC_MODE_DIRECT_LEVEL_OVERRIDE ||
			mode_eff == HPC_MODE_PWM) begin
			pwr_state <= HPC_PWR_ACTIVE;
		end else if (seq_done) begin
			pwr_state <= top_ctl_r[HPC_BIT_STANDBY] ?
				HPC_PWR_STANDBY : HPC_PWR_IDLE; // [RQ3]
		end else if (run_stop_wr || pwr_state == HPC_PWR_ACTIVE) begin
			// Standby after playback persists until software stops
			pwr_state <= HPC_PWR_IDLE; // [RQ2]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			playing <= 1'b0;
		end else begin
			playing <= seq_playing;
		end
	end

	// ==========================================================
	// Drive command
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drive <= '0;
		end else begin
			drive.active <= (seq_playing && mode_mem) ||
				mode_eff == HPC_MODE_DIRECT_LEVEL_OVERRIDE ||
				mode_eff == HPC_MODE_PWM;
			drive.mode <= mode_eff; // [RQ4] [RQ13]
			drive.factor <= (mode_eff == HPC_MODE_DIRECT_LEVEL_OVERRIDE) ?
				factor : 9'sh000; // [RQ5]
			drive.use_abs_max <= use_abs; // [RQ6]
			drive.use_nom_max <= use_nom; // [RQ6]
			drive.timebase_sel <= seq_cfg_r[HPC_BIT_TIMEBASE]; // [RQ8]
			drive.wave_gen_sel <= seq_cfg_r[HPC_BIT_WAVEGEN]; // [RQ9]
		end
	end

	// ==========================================================
	// Assertions
	a_run_clear_idle: assert property ( // [RQ2]
		@(posedge pclk) disable iff (!presetn)
		wr_en && mapped && wr_lane0 && idx[7:0] == HPC_IDX_TOP_CTL &&
		!pwdata[HPC_BIT_RUN] |=> ##1 !seq_playing)
		else $error("playback did not stop after run cleared");
	a_run_start: assert property ( // [RQ1]
		@(posedge pclk) disable iff (!presetn)
		$rose(top_ctl_r[HPC_BIT_RUN]) && mode_mem |=> seq_playing)
		else $error("playback did not start");
	a_chain_self_clear: assert property ( // [RQ12]
		@(posedge pclk) disable iff (!presetn)
		next_start |=> !seq_cfg_r[HPC_BIT_CHAIN])
		else $error("chain bit not cleared");
	a_chain_continue: assert property ( // [RQ11]
		@(posedge pclk) disable iff (!presetn)
		next_start |-> seq_playing && !seq_done)
		else $error("chained sequence stopped");
	a_standby_after: assert property ( // [RQ3]
		@(posedge pclk) disable iff (!presetn)
		seq_done && top_ctl_r[HPC_BIT_STANDBY] &&
		mode_eff != HPC_MODE_DIRECT_LEVEL_OVERRIDE &&
		mode_eff != HPC_MODE_PWM |=> pwr_state == HPC_PWR_STANDBY)
		else $error("standby not entered");
	a_reserved_mode: assert property ( // [RQ13]
		@(posedge pclk) disable iff (!presetn)
		top_ctl_r[2:0] > 3'h4 |=> drive.mode == HPC_MODE_INACTIVE &&
		!drive.active)
		else $error("reserved mode not inactive");
	a_neg_factor: assert property ( // [RQ7]
		@(posedge pclk) disable iff (!presetn)
		mode_eff == HPC_MODE_DIRECT_LEVEL_OVERRIDE && ovr_lvl_r[7] |=>
		drive.factor == ($past(accel_en) ? 9'sh000 :
		{1'b1, $past(ovr_lvl_r)}))
		else $error("negative factor wrong");
	a_full_scale: assert property ( // [RQ5]
		@(posedge pclk) disable iff (!presetn)
		mode_eff == HPC_MODE_DIRECT_LEVEL_OVERRIDE &&
		ovr_lvl_r == HPC_OVR_FULL |=>
		drive.factor == 9'sh07F)
		else $error("full scale factor wrong");
	a_timebase_out: assert property ( // [RQ8] [RQ9]
		@(posedge pclk) disable iff (!presetn)
		##1 drive.timebase_sel == $past(seq_cfg_r[HPC_BIT_TIMEBASE]) &&
		drive.wave_gen_sel == $past(seq_cfg_r[HPC_BIT_WAVEGEN]))
		else $error("timebase or wave select wrong");
	c_chain: cover property (@(posedge pclk) disable iff (!presetn)
		next_start);
	c_done_standby: cover property (@(posedge pclk) disable iff (!presetn)
		seq_done && top_ctl_r[HPC_BIT_STANDBY]);
	c_override_neg: cover property (@(posedge pclk) disable iff (!presetn)
		drive.factor < 0);
endmodule : hpc_top
`default_nettype wire

// ===== sim/haptic_playback_control_tb.sv
// Register-level testbench for the haptic playback control bank
`timescale 1ns/1ps
`default_nettype none
module haptic_playback_control_tb;
	import hpc_pkg::*;
	// ==========================================================
	// Signals
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hF;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic accel_en = 1'b0;
	hpc_drive_t drive;
	hpc_pwr_t pwr_state;
	logic playing;
	int n_fail = 0;
	int checks = 0;
	logic [31:0] q;
	logic err;
	localparam logic [11:0] A_TOP = {2'b00, HPC_IDX_TOP_CTL, 2'b00};
	localparam logic [11:0] A_OVR = {2'b00, HPC_IDX_OVR_LVL, 2'b00};
	localparam logic [11:0] A_SEQ = {2'b00, HPC_IDX_SEQ_CFG, 2'b00};
	localparam logic [11:0] A_LEN = {2'b00, HPC_IDX_LEN, 2'b00};
	localparam logic [11:0] A_ACC = {2'b00, HPC_IDX_ACCEL, 2'b00};
	localparam logic [11:0] A_STA = {2'b00, HPC_IDX_STATUS, 2'b00};
	always #25 pclk = ~pclk;
	hpc_top u_hpc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.accel_en(accel_en), .drive(drive), .pwr_state(pwr_state),
		.playing(playing));
	// ==========================================================
	// Tasks
	task automatic end_of_test;
		$display("Comparisons %0d, mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] s);
		checks++;
		if (s !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			chk("pready", 1, 0);
		end
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rd(input string nm, input logic [11:0] a,
		input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, e, q);
	endtask : rd
	task automatic wait_play(input logic v);
		int n;
		n = 0;
		while (playing !== v && n < 200) begin
			@(posedge pclk);
			n++;
		end
		chk("playing", v, playing);
	endtask : wait_play
	task automatic ovr(input logic a, input logic [7:0] c,
		input logic [8:0] e);
		accel_en <= a;
		wr(A_OVR, c);
		repeat (3) @(posedge pclk);
		chk("factor", e, $unsigned(drive.factor));
		chk("use_abs", a, drive.use_abs_max);
		chk("use_nom", 1, drive.use_nom_max);
	endtask : ovr
	// ==========================================================
	// Watchdog
	initial begin
		#(50 * 30000);
		n_fail++;
		$display("MISMATCH watchdog expected done seen hang");
		end_of_test();
	end
	// ==========================================================
	// Tests
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		// Reset values and idle outputs
		rd("top_ctl", A_TOP, HPC_RST_TOP_CTL);
		rd("ovr_lvl", A_OVR, HPC_RST_OVR_LVL);
		rd("seq_cfg", A_SEQ, HPC_RST_SEQ_CFG);
		chk("pwr", HPC_PWR_IDLE, pwr_state);
		// Mode decode, reserved codes inactive
		for (int m = 0; m < 8; m++) begin
			wr(A_TOP, m);
			repeat (2) @(posedge pclk);
			rd("mode rb", A_TOP, m);
			if (m >= 1 && m <= 4) begin
				chk("mode", m, drive.mode);
				chk("active", (m == 1 || m == 2), drive.active);
			end else begin
				chk("inactive", 0, drive.active);
				chk("rsvd mode", 0, drive.mode);
			end
		end
		// Override scaling, signed and clamped to zero with acceleration
		wr(A_TOP, HPC_MODE_DIRECT_LEVEL_OVERRIDE);
		ovr(1'b0, 8'h7F, 9'h07F);
		ovr(1'b0, 8'h7E, 9'h07E);
		ovr(1'b0, 8'h01, 9'h001);
		ovr(1'b0, 8'h00, 9'h000);
		ovr(1'b0, 8'hFF, 9'h1FF);
		ovr(1'b0, 8'h80, 9'h180);
		ovr(1'b1, 8'h7F, 9'h07F);
		ovr(1'b1, 8'h80, 9'h000);
		ovr(1'b1, 8'hFF, 9'h000);
		rd("accel", A_ACC, 32'h1);
		chk("slverr ok", 0, err);
		// Masked write lane leaves the register alone
		pstrb <= 4'h0;
		wr(A_OVR, 32'h55);
		pstrb <= 4'hF;
		rd("ovr strb", A_OVR, 32'hFF);
		// Unmapped address refused
		wr(12'h004, 32'hFF);
		chk("slverr w", 1, err);
		rd("unmapped", 12'h004, 32'h0);
		chk("slverr r", 1, err);
		// Timebase and wave generator select
		wr(A_SEQ, 32'h4);
		repeat (2) @(posedge pclk);
		chk("timebase", 1, drive.timebase_sel);
		chk("wavegen", 0, drive.wave_gen_sel);
		wr(A_SEQ, 32'h2); // Custom sine drive, sensing off
		repeat (2) @(posedge pclk);
		chk("timebase", 0, drive.timebase_sel);
		chk("wavegen", 1, drive.wave_gen_sel);
		wr(A_SEQ, 32'h0); // Normal drive, sensing on
		// Playback to completion, idle then standby
		wr(A_LEN, 32'h8);
		wr(A_TOP, 32'h13);
		wait_play(1'b1);
		@(posedge pclk);
		chk("pwr act", HPC_PWR_ACTIVE, pwr_state);
		wait_play(1'b0);
		repeat (2) @(posedge pclk);
		chk("pwr idle", HPC_PWR_IDLE, pwr_state);
		rd("run clr", A_TOP, 32'h03);
		wr(A_TOP, 32'h1B);
		wait_play(1'b1);
		wait_play(1'b0);
		repeat (2) @(posedge pclk);
		chk("pwr stby", HPC_PWR_STANDBY, pwr_state);
		// Stop in mid-sequence
		wr(A_LEN, 32'h40);
		wr(A_TOP, 32'h1C);
		wait_play(1'b1);
		repeat (4) @(posedge pclk);
		wr(A_TOP, 32'h04);
		repeat (3) @(posedge pclk);
		chk("stopped", 0, playing);
		chk("pwr stop", HPC_PWR_IDLE, pwr_state);
		// Chained sequences
		wr(A_LEN, 32'h10);
		wr(A_SEQ, 32'h1);
		rd("chain set", A_SEQ, 32'h1);
		wr(A_TOP, 32'h13);
		wait_play(1'b1);
		apb(1'b0, A_SEQ, 32'h0);
		for (int i = 0; i < 20 && q[HPC_BIT_CHAIN] !== 1'b0; i++) begin
			apb(1'b0, A_SEQ, 32'h0);
		end
		chk("chain clr", 0, q[HPC_BIT_CHAIN]);
		chk("chained", 1, playing);
		wait_play(1'b0);
		// Status: done, idle, one chained start; done clears on write one
		rd("status", A_STA, 32'h11);
		wr(A_STA, 32'h1);
		rd("status clr", A_STA, 32'h10);
		end_of_test();
	end
endmodule : haptic_playback_control_tb
`default_nettype wire
